// ==== src/reset_watchdog_pkg.sv ====
// Constants, register map and state types for the reset-cause and watchdog block.
package reset_watchdog_pkg;

    // Register map on APB. The status register keeps its printed index; the others are free byte addresses.
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned STATUS_INDEX   = 3;
    localparam logic [7:0]  STATUS_ADDR    = 8'(4 * STATUS_INDEX);
    localparam logic [7:0]  OPTION_ADDR    = 8'h10;
    localparam logic [7:0]  IRQ_STAT_ADDR  = 8'h14;
    localparam logic [7:0]  IRQ_MASK_ADDR  = 8'h18;
    localparam logic [7:0]  STATE_ADDR     = 8'h1C;

    // Core status register layout.
    localparam int unsigned STATUS_W       = 8;
    localparam int unsigned PAGE_LSB       = 5;
    localparam int unsigned PAGE_W         = 3;
    localparam int unsigned TIMEOUT_BIT    = 4;
    localparam int unsigned POWERDOWN_BIT  = 3;
    localparam int unsigned ARITH_W        = 3;
    localparam logic [7:0]  STATUS_POR     = 8'h18;
    localparam logic [7:0]  STATUS_SW_MASK = 8'hE7;

    // Option register layout.
    localparam int unsigned OPTION_W       = 6;
    localparam logic [5:0]  OPTION_RESET   = 6'h3F;
    localparam int unsigned ASSIGN_BIT     = 3;
    localparam int unsigned RATIO_LSB      = 0;
    localparam int unsigned RATIO_W        = 3;

    // Interrupt status and mask layout.
    localparam int unsigned IRQ_W          = 2;
    localparam int unsigned IRQ_WATCHDOG   = 0;
    localparam int unsigned IRQ_MCLEAR     = 1;

    // Flag pairs {timeout, powerdown} per reset cause.
    localparam logic [1:0]  FLAGS_MC_WAKE  = 2'h2;
    localparam logic [1:0]  FLAGS_WD_RUN   = 2'h1;
    localparam logic [1:0]  FLAGS_WD_WAKE  = 2'h0;

    // Watchdog timing.
    localparam int unsigned PRESC_W        = 8;
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned TIMEOUT_MS     = 18;
    localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * CLK_MHZ * 1000;

    typedef enum logic [0:0] {
        CORE_RUN   = 1'b0,
        CORE_SLEEP = 1'b1
    } core_state_t;

endpackage

// ==== src/reset_cause_and_watchdog.sv ====
// Reset-cause recorder, watchdog timer and shared prescaler with an APB register slave.
//
// Behaviour
// - Five reset causes: power-on, pin run, pin wake, watchdog run, watchdog wake.
// - Pin or watchdog wake-up from sleep performs a full reset, no resume.
// - Unaffected bits power up arbitrary and keep their value on non-power-on resets; here power-on clears them to zero.
// - Timeout and powerdown flags sit at status bits 4 and 3; power-on sets both.
// - Pin reset while running leaves both flags unchanged.
// - Pin wake-up sets timeout flag and clears powerdown flag.
// - Watchdog reset while running clears timeout flag, sets powerdown flag.
// - Watchdog wake-up clears both flags.
// - Status resets to 0001 1xxx on power-on, 000q quuu otherwise; here power-on loads 0001 1000.
// - Watchdog counts on its own free-running time base, also during sleep.
// - Watchdog time-out causes a device reset when running and when sleeping.
// - Enable fuse at zero disables the watchdog for good.
// - One 8-bit prescaler serves either core timer or watchdog, never both.
// - Assignment bit and three-bit ratio in option bits 3..0 select use and ratio.
// - Unprescaled time-out is 18 ms, about 2.3 s at ratio 1:128.
// - Clear instruction restarts watchdog and prescaler when assigned; software must repeat it.
// - Sleep instruction restarts watchdog and prescaler when assigned, for longest sleep.
// - Every reset sets the option bits to all ones.
`timescale 1ns/1ps
module reset_cause_and_watchdog #(
    parameter int unsigned TIMEOUT_CYCLES = reset_watchdog_pkg::TIMEOUT_CYCLES,
    parameter int unsigned PRESC_W        = reset_watchdog_pkg::PRESC_W
) (
    // Clock and power-on reset
    input  wire logic                                      pclk,
    input  wire logic                                      presetn,
    // APB slave
    input  wire logic                                      psel,
    input  wire logic                                      penable,
    input  wire logic                                      pwrite,
    input  wire logic [reset_watchdog_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [reset_watchdog_pkg::DATA_W-1:0]     pwdata,
    output logic      [reset_watchdog_pkg::DATA_W-1:0]     prdata,
    output logic                                           pready,
    output logic                                           pslverr,
    // Pins and configuration
    input  wire logic                                      master_clear_pin_n,
    input  wire logic                                      watchdog_enable_fuse,
    // Processor core
    input  wire logic                                      clear_watchdog_instruction,
    input  wire logic                                      sleep_instruction,
    input  wire logic                                      core_timer_edge,
    output logic                                           core_timer_tick,
    output logic                                           device_reset,
    output logic                                           core_sleeping,
    output logic      [reset_watchdog_pkg::STATUS_W-1:0]   core_status_flags,
    output logic      [reset_watchdog_pkg::OPTION_W-1:0]   core_option,
    // Interrupt
    output logic                                           irq
);

    localparam int unsigned CNT_W = $clog2(TIMEOUT_CYCLES) + 1;

    reset_watchdog_pkg::core_state_t              state_r;
    logic [reset_watchdog_pkg::STATUS_W-1:0]      status_r;
    logic [reset_watchdog_pkg::OPTION_W-1:0]      option_r;
    logic [reset_watchdog_pkg::IRQ_W-1:0]         irq_stat_r;
    logic [reset_watchdog_pkg::IRQ_W-1:0]         irq_mask_r;
    logic [reset_watchdog_pkg::IRQ_W-1:0]         irq_stat_nxt;
    logic [CNT_W-1:0]                             base_cnt_r;
    logic [PRESC_W-1:0]                           presc_r;
    logic                                         mclear_prev_r;
    logic                                         fuse_r;
    logic                                         fuse_loaded_r;
    logic                                         pready_r;
    logic                                         pslverr_r;
    logic [reset_watchdog_pkg::DATA_W-1:0]        prdata_r;
    logic                                         device_reset_r;
    logic                                         core_timer_tick_r;
    logic                                         irq_r;

    logic                                         watchdog_on;
    logic                                         assign_wd;
    logic [reset_watchdog_pkg::RATIO_W-1:0]       ratio;
    logic [PRESC_W-1:0]                           wd_mask;
    logic [PRESC_W-1:0]                           tm_mask;
    logic                                         base_tick;
    logic                                         watchdog_fire;
    logic                                         mclear_event;
    logic                                         reset_event;
    logic                                         running;
    logic                                         clear_req;
    logic                                         sleep_req;
    logic                                         watchdog_restart;
    logic                                         apb_setup;
    logic                                         apb_write;
    logic [1:0]                                   flags_cur;
    logic [1:0]                                   flags_nxt;

    assign running   = (state_r == reset_watchdog_pkg::CORE_RUN);
    // The core clock is stopped in sleep, so instructions only count while running.
    assign clear_req = clear_watchdog_instruction && running;
    assign sleep_req = sleep_instruction && running;
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready_r && pwrite;

    assign watchdog_on = fuse_r && fuse_loaded_r;
    assign assign_wd = option_r[reset_watchdog_pkg::ASSIGN_BIT];
    assign ratio     = option_r[reset_watchdog_pkg::RATIO_LSB +: reset_watchdog_pkg::RATIO_W];
    assign wd_mask   = PRESC_W'((32'h1 << ratio) - 32'h1);
    // The core timer sees ratios from 1:2 upward, one step above the watchdog's.
    assign tm_mask   = PRESC_W'((32'h2 << ratio) - 32'h1);

    assign base_tick     = watchdog_on && (base_cnt_r == CNT_W'(TIMEOUT_CYCLES - 1));
    assign watchdog_fire = base_tick && (!assign_wd || ((presc_r & wd_mask) == wd_mask));
    assign mclear_event  = mclear_prev_r && !master_clear_pin_n;
    assign reset_event   = mclear_event || watchdog_fire;
    assign watchdog_restart = clear_req || sleep_req || reset_event;

    assign flags_cur = {status_r[reset_watchdog_pkg::TIMEOUT_BIT], status_r[reset_watchdog_pkg::POWERDOWN_BIT]};

    // A pin reset outranks a watchdog time-out in the same cycle.
    always_comb begin
        flags_nxt = flags_cur;
        if (mclear_event) begin
            flags_nxt = running ? flags_cur : reset_watchdog_pkg::FLAGS_MC_WAKE;
        end else if (watchdog_fire) begin
            flags_nxt = running ? reset_watchdog_pkg::FLAGS_WD_RUN : reset_watchdog_pkg::FLAGS_WD_WAKE;
        end
    end

    // Fuse is caught once after reset release, so a later change cannot re-enable it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_r        <= 1'b0;
            fuse_loaded_r <= 1'b0;
        end else if (!fuse_loaded_r) begin
            fuse_r        <= watchdog_enable_fuse;
            fuse_loaded_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclear_prev_r <= 1'b1;
        end else begin
            mclear_prev_r <= master_clear_pin_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= reset_watchdog_pkg::CORE_RUN;
        end else begin
            case (state_r)
                reset_watchdog_pkg::CORE_RUN: begin
                    if (!reset_event && sleep_instruction) begin
                        state_r <= reset_watchdog_pkg::CORE_SLEEP;
                    end
                end
                reset_watchdog_pkg::CORE_SLEEP: begin
                    if (reset_event) begin
                        state_r <= reset_watchdog_pkg::CORE_RUN;
                    end
                end
                default: begin
                    state_r <= reset_watchdog_pkg::CORE_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_reset_r <= 1'b0;
        end else begin
            device_reset_r <= reset_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt_r <= '0;
        end else if (!watchdog_on || watchdog_restart || base_tick) begin
            base_cnt_r <= '0;
        end else begin
            base_cnt_r <= base_cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= '0;
        end else if (reset_event || apb_write && paddr == reset_watchdog_pkg::OPTION_ADDR) begin
            presc_r <= '0;
        end else if (assign_wd) begin
            if (!watchdog_on || clear_req || sleep_req) begin
                presc_r <= '0;
            end else if (base_tick) begin
                presc_r <= presc_r + PRESC_W'(1);
            end
        end else if (core_timer_edge) begin
            presc_r <= presc_r + PRESC_W'(1);
        end
    end

    // timer unscaled when watchdog owns it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_timer_tick_r <= 1'b0;
        end else if (assign_wd) begin
            core_timer_tick_r <= core_timer_edge;
        end else begin
            core_timer_tick_r <= core_timer_edge && ((presc_r & tm_mask) == tm_mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= reset_watchdog_pkg::STATUS_POR;
        end else if (reset_event) begin
            status_r <= {{reset_watchdog_pkg::PAGE_W{1'b0}}, flags_nxt,
                         status_r[reset_watchdog_pkg::ARITH_W-1:0]};
        end else if (apb_write && paddr == reset_watchdog_pkg::STATUS_ADDR) begin
            status_r <= (status_r & ~reset_watchdog_pkg::STATUS_SW_MASK)
                      | (pwdata[reset_watchdog_pkg::STATUS_W-1:0] & reset_watchdog_pkg::STATUS_SW_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_r <= reset_watchdog_pkg::OPTION_RESET;
        end else if (reset_event) begin
            option_r <= reset_watchdog_pkg::OPTION_RESET;
        end else if (apb_write && paddr == reset_watchdog_pkg::OPTION_ADDR) begin
            option_r <= pwdata[reset_watchdog_pkg::OPTION_W-1:0];
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (apb_write && paddr == reset_watchdog_pkg::IRQ_STAT_ADDR) begin
            irq_stat_nxt = irq_stat_nxt & ~pwdata[reset_watchdog_pkg::IRQ_W-1:0];
        end
        if (watchdog_fire) begin
            irq_stat_nxt[reset_watchdog_pkg::IRQ_WATCHDOG] = 1'b1;
        end
        if (mclear_event) begin
            irq_stat_nxt[reset_watchdog_pkg::IRQ_MCLEAR] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_r      <= |(irq_stat_r & irq_mask_r);
            if (apb_write && paddr == reset_watchdog_pkg::IRQ_MASK_ADDR) begin
                irq_mask_r <= pwdata[reset_watchdog_pkg::IRQ_W-1:0];
            end
        end
    end

    // Zero-wait slave: read data and the answer are prepared in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
            if (apb_setup) begin
                case (paddr)
                    reset_watchdog_pkg::STATUS_ADDR:   prdata_r <= 32'(status_r);
                    reset_watchdog_pkg::OPTION_ADDR:   prdata_r <= 32'(option_r);
                    reset_watchdog_pkg::IRQ_STAT_ADDR: prdata_r <= 32'(irq_stat_r);
                    reset_watchdog_pkg::IRQ_MASK_ADDR: prdata_r <= 32'(irq_mask_r);
                    reset_watchdog_pkg::STATE_ADDR:    prdata_r <= 32'({watchdog_on, state_r});
                    default: begin
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign device_reset      = device_reset_r;
    assign core_sleeping     = state_r;
    assign core_status_flags = status_r;
    assign core_option       = option_r;
    assign core_timer_tick   = core_timer_tick_r;
    assign irq               = irq_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_run_cycle;
        running && watchdog_on && !watchdog_restart && !base_tick;
    endsequence

    sequence seq_sleep_entry;
        sleep_req && !reset_event ##1 !running;
    endsequence

    AST_POR_STATUS: assert property (
        !$past(presetn) |-> status_r == reset_watchdog_pkg::STATUS_POR
    ) else $error("Status after power-on is not 0001 1000.");

    AST_PIN_RUN_KEEPS: assert property (
        mclear_event && running |=> flags_cur == $past(flags_cur)
    ) else $error("Pin reset while running changed the flags.");

    AST_PIN_WAKE_FLAGS: assert property (
        mclear_event && !running |=> flags_cur == reset_watchdog_pkg::FLAGS_MC_WAKE
    ) else $error("Pin wake-up flags wrong.");

    AST_WD_RUN_FLAGS: assert property (
        watchdog_fire && !mclear_event && running |=> flags_cur == reset_watchdog_pkg::FLAGS_WD_RUN
    ) else $error("Watchdog reset flags wrong.");

    AST_WD_WAKE_FLAGS: assert property (
        watchdog_fire && !mclear_event && !running |=> flags_cur == reset_watchdog_pkg::FLAGS_WD_WAKE
    ) else $error("Watchdog wake-up flags wrong.");

    AST_WAKE_IS_RESET: assert property (
        reset_event && !running |=> device_reset && running ##1 !device_reset
    ) else $error("Wake-up did not produce a one-cycle reset back to run.");

    AST_RESET_STATUS: assert property (
        reset_event |=> status_r[reset_watchdog_pkg::PAGE_LSB +: reset_watchdog_pkg::PAGE_W] == '0
            && status_r[reset_watchdog_pkg::ARITH_W-1:0] == $past(status_r[reset_watchdog_pkg::ARITH_W-1:0])
    ) else $error("Status after reset lost arithmetic bits or kept page bits.");

    AST_OPTION_ONES: assert property (
        reset_event |=> option_r == reset_watchdog_pkg::OPTION_RESET
    ) else $error("Option not all ones after reset.");

    AST_FUSE_OFF: assert property (
        fuse_loaded_r && !fuse_r |-> !watchdog_fire && base_cnt_r == '0
    ) else $error("Disabled watchdog is counting.");

    AST_SLEEP_COUNTS: assert property (
        seq_sleep_entry ##0 (watchdog_on && !reset_event) |=> base_cnt_r == CNT_W'(1)
    ) else $error("Watchdog stalled after entering sleep.");

    AST_RUN_COUNTS: assert property (
        seq_run_cycle |=> base_cnt_r == $past(base_cnt_r) + CNT_W'(1)
    ) else $error("Watchdog base counter did not advance.");

    AST_CLEAR_RESTART: assert property (
        clear_req && !reset_event |=> base_cnt_r == '0 && (!$past(assign_wd) || presc_r == '0)
    ) else $error("Clear instruction did not restart the watchdog.");

    AST_TIMER_UNSCALED: assert property (
        assign_wd && core_timer_edge |=> core_timer_tick
    ) else $error("Core timer was prescaled while prescaler belongs to watchdog.");

endmodule

// ==== tb/core_model.sv ====
// Processor-core model that issues clear and sleep instructions as one-cycle pulses.
`timescale 1ns/1ps
module core_model (
    // Clock
    input  wire logic pclk,
    // Bench control
    input  wire logic kick_en,
    // Instructions
    output logic      clear_watchdog_instruction,
    output logic      sleep_instruction
);
    logic [2:0] gap_r = 3'h0;

    initial clear_watchdog_instruction = 1'h0;
    initial sleep_instruction = 1'h0;

    // periodic clear
    // Six cycles apart, well inside the shortest time-out that the bench sets.
    always @(posedge pclk) begin
        gap_r <= (kick_en && gap_r != 3'h5) ? gap_r + 3'h1 : 3'h0;
        if (kick_en || clear_watchdog_instruction) begin
            clear_watchdog_instruction <= kick_en && gap_r == 3'h5;
        end
    end

    // The clocked block above drops the pulse, so it is never written twice in one step.
    task automatic do_clear;
        @(posedge pclk);
        clear_watchdog_instruction <= 1'h1;
        @(posedge pclk);
    endtask

    task automatic do_sleep;
        @(posedge pclk);
        sleep_instruction <= 1'h1;
        @(posedge pclk);
        sleep_instruction <= 1'h0;
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the reset-cause and watchdog block.
`timescale 1ns/1ps
module tb_top;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, irq, device_reset, core_sleeping, core_timer_tick;
    logic        master_clear_pin_n = 1'h1, watchdog_enable_fuse = 1'h1, core_timer_edge = 1'h0;
    logic        kick_en = 1'h0, clear_watchdog_instruction, sleep_instruction;
    logic [7:0]  core_status_flags;
    logic [5:0]  core_option;
    int          fails = 0, samples_checked = 0, ticks = 0, c;

    reset_cause_and_watchdog #(.TIMEOUT_CYCLES(16), .PRESC_W(8)) uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .master_clear_pin_n, .watchdog_enable_fuse, .clear_watchdog_instruction, .sleep_instruction,
        .core_timer_edge, .core_timer_tick, .device_reset, .core_sleeping, .core_status_flags,
        .core_option, .irq);
    core_model core (.pclk, .kick_en, .clear_watchdog_instruction, .sleep_instruction);

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) if (core_timer_tick === 1'h1) ticks <= ticks + 1;

    task automatic print_verdict;
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            fails++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
        // A slave that never answers counts as a mismatch.
        if (pready !== 1'h1) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic wait_rst(input int lim);
        c = 0;
        while (device_reset !== 1'h1 && c < lim) begin
            @(posedge pclk);
            c++;
        end
    endtask

    task automatic pin_reset;
        @(posedge pclk);
        master_clear_pin_n <= 1'h0;
        @(posedge pclk);
        master_clear_pin_n <= 1'h1;
        wait_rst(5);
    endtask

    task automatic por(input logic f);
        @(posedge pclk);
        presetn <= 1'h0;
        watchdog_enable_fuse <= f;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
    endtask

    // The watchdog counter is cleared first, so the wait measures one whole period.
    task automatic period(input logic [5:0] opt, input int e);
        apb(1'h1, reset_watchdog_pkg::OPTION_ADDR, 32'(opt));
        core.do_clear();
        wait_rst(e + 50);
        chk("wd_period", 32'h1, 32'(c >= e - 2 && c <= e + 2));
    endtask

    task automatic timer(input logic [5:0] opt, input int e);
        int t0;
        apb(1'h1, reset_watchdog_pkg::OPTION_ADDR, 32'(opt));
        t0 = ticks;
        repeat (4) begin
            @(posedge pclk);
            core_timer_edge <= 1'h1;
            @(posedge pclk);
            core_timer_edge <= 1'h0;
        end
        repeat (3) @(posedge pclk);
        chk("timer_ticks", 32'(e), 32'(ticks - t0));
    endtask

    initial begin
        por(1'h1);
        rdchk("flags_por", reset_watchdog_pkg::STATUS_ADDR, 32'h18); // power-on
        rdchk("option_por", reset_watchdog_pkg::OPTION_ADDR, 32'h3F); // option reset
        apb(1'h0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rd);
        apb(1'h1, reset_watchdog_pkg::IRQ_MASK_ADDR, 32'h3);
        apb(1'h1, reset_watchdog_pkg::STATUS_ADDR, 32'hE5);
        rdchk("flags_ro", reset_watchdog_pkg::STATUS_ADDR, 32'hFD); // flags read-only
        pin_reset();
        chk("pin_pulse", 32'h1, 32'(c < 5)); // pin cause
        rdchk("flags_pin_run", reset_watchdog_pkg::STATUS_ADDR, 32'h1D); // kept bits
        chk("irq_pin", 32'h1, 32'(irq));
        apb(1'h1, reset_watchdog_pkg::IRQ_STAT_ADDR, 32'h3);
        rdchk("irq_stat_clr", reset_watchdog_pkg::IRQ_STAT_ADDR, 32'h0);
        chk("irq_clr", 32'h0, 32'(irq));
        apb(1'h1, reset_watchdog_pkg::IRQ_MASK_ADDR, 32'h2);
        core.do_clear();
        apb(1'h1, reset_watchdog_pkg::OPTION_ADDR, 32'h37);
        kick_en <= 1'h1;
        wait_rst(60);
        chk("kick_holds", 32'h3C, 32'(c)); // clear restarts
        kick_en <= 1'h0;
        wait_rst(40);
        chk("wd_run_pulse", 32'h1, 32'(c < 40)); // watchdog reset
        rdchk("flags_wd_run", reset_watchdog_pkg::STATUS_ADDR, 32'h0D); // watchdog run
        chk("option_wd", 32'h3F, 32'(core_option)); // option reset
        chk("irq_masked", 32'h0, 32'(irq));
        rdchk("irq_stat_wd", reset_watchdog_pkg::IRQ_STAT_ADDR, 32'h1);
        apb(1'h1, reset_watchdog_pkg::OPTION_ADDR, 32'h37);
        core.do_sleep();
        @(posedge pclk);
        chk("sleeping", 32'h1, 32'(core_sleeping)); // sleep entry
        rdchk("state_sleep", reset_watchdog_pkg::STATE_ADDR, 32'h3); // sleeping, watchdog on
        pin_reset();
        chk("wake_run", 32'h0, 32'(core_sleeping)); // full reset
        rdchk("flags_pin_wake", reset_watchdog_pkg::STATUS_ADDR, 32'h15); // pin wake
        apb(1'h1, reset_watchdog_pkg::OPTION_ADDR, 32'h37);
        // Sleep must come before the pin reset's own watchdog period runs out.
        repeat (2) @(posedge pclk);
        core.do_sleep();
        wait_rst(40);
        chk("sleep_restart", 32'h1, 32'(c >= 14 && c <= 18)); // sleep wake
        rdchk("flags_wd_wake", reset_watchdog_pkg::STATUS_ADDR, 32'h05); // watchdog wake
        chk("flags_out", 32'h05, 32'(core_status_flags)); // status output copy
        period(6'h37, 16); // unprescaled period
        period(6'h39, 32); // ratio one
        period(6'h3B, 128); // ratio three
        period(6'h3F, 2048); // largest ratio
        kick_en <= 1'h1;
        timer(6'h3F, 4); // timer unscaled
        timer(6'h30, 2); // timer scaled
        kick_en <= 1'h0;
        por(1'h0);
        rdchk("flags_por2", reset_watchdog_pkg::STATUS_ADDR, 32'h18); // second power-on
        rdchk("state_off", reset_watchdog_pkg::STATE_ADDR, 32'h0); // watchdog disabled
        apb(1'h1, reset_watchdog_pkg::OPTION_ADDR, 32'h37);
        wait_rst(100);
        chk("fuse_off", 32'h64, 32'(c)); // disabled watchdog
        print_verdict();
    end

    initial begin
        #100000;
        fails++;
        print_verdict();
    end
endmodule
